// ---- logic/dstp_pkg.sv ----
/*
 * Shared constants and carrier types of the debug status and trace port.
 * Assumes a single processor clock domain; the shift clock arrives from outside.
 */
`default_nettype none

package dstp_pkg;
   // ----------------------------------------------------------------
   // widths and encodings
   // ----------------------------------------------------------------
   localparam int STATUS_W = 4;
   localparam int FRAME_W = 17;
   localparam logic [3:0] STATUS_IDLE = 4'h0;
   localparam logic [3:0] STATUS_START_C = 4'hC;
   localparam logic [3:0] STATUS_START_D = 4'hD;
   localparam logic [3:0] STATUS_START_F = 4'hF;
   localparam logic [3:0] NIBBLE_RESET = 4'h0;
   localparam logic [4:0] BIT_COUNT_RESET = 5'h00;
   localparam logic [4:0] BIT_COUNT_LAST = 5'h10;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLOCK_MHZ = 100;
   localparam int OUT_DELAY_NS = 20;
   localparam int OUT_DELAY_CYC = (OUT_DELAY_NS * CLOCK_MHZ + 999) / 1000;
   localparam logic [2:0] OUT_DELAY_CNT = 3'(OUT_DELAY_CYC);

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] statusCode;
      logic [3:0] dataNibble;
   } dstp_trace_s;

   typedef struct packed {
      logic [3:0] coreStatusCode;
      logic [3:0] debugDataNibble;
      logic statusAllOnes;
      logic statusSampleClock;
   } dstp_pins_s;

   typedef enum logic [1:0] {
      ST_HALTED = 2'b00,
      ST_RUN = 2'b01,
      ST_FROZEN = 2'b10
   } dstp_clk_e;
endpackage : dstp_pkg

`default_nettype wire

// ---- logic/dstp_port.sv ----
/*
 * Debug status and trace port: serial command/response link and trace outputs.
 * Assumes the core supplies status and captured data each processor clock and
 * that the debug module consumes received frames and supplies response frames.
 * Assumes the probe holds the shift clock high and low for four cycles or more.
 */
`default_nettype none

// Summary of operation
// - the serial input is synchronised and a bit is taken only once the shift clock is seen high.
// - the serial output comes from a register and changes a fixed delay after the clock is seen high.
// - the data nibble carries captured processor data and breakpoint status.
// - the sample clock is a delayed processor clock rising mid-window of status and nibble.
// - with the clock disable set, sample clock, status and nibble stop while triggers stay live.
// - clearing the clock disable restores toggling and the probe resynchronises.
// - the sample clock stays still after reset until the first 0xC, 0xD or 0xF status.
// - the status code is processor-clock synchronous and independent of bus transfers.
// - the all-ones output is the AND of the four status bits.

module dstp_port (
   input wire logic clock,
   input wire logic rstn,
   input wire logic debugShiftClock,
   input wire logic debugSerialIn,
   output logic debugSerialOut,
   input wire dstp_pkg::dstp_trace_s coreTrace,
   input wire logic statusClockDisable,
   input wire logic triggerIn,
   output logic triggerOut,
   output dstp_pkg::dstp_pins_s tracePins,
   output logic [dstp_pkg::FRAME_W-1:0] rxFrame,
   output logic rxValid,
   input wire logic [dstp_pkg::FRAME_W-1:0] txFrame,
   input wire logic txLoad
);
   import dstp_pkg::*;

   // the three codes that open reset exception processing
   function automatic logic isStartCode(input logic [3:0] code);
      isStartCode = (code == STATUS_START_C) || (code == STATUS_START_D) ||
                    (code == STATUS_START_F);
   endfunction : isStartCode

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sclkSync_reg;
   logic [2:0] sdiSync_reg;
   logic sclkLevel_reg;
   logic sclkLevel_next;
   wire logic sclkAgree = (sclkSync_reg[2] == sclkSync_reg[1]);
   wire logic sdiAgree = (sdiSync_reg[2] == sdiSync_reg[1]);
   logic sdiLevel_reg;

   // a change counts once the last two stages agree, so a one-cycle glitch is dropped
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclkSync_reg <= 3'h0;
         sdiSync_reg <= 3'h0;
      end else begin
         sclkSync_reg <= {sclkSync_reg[1:0], debugShiftClock};
         sdiSync_reg <= {sdiSync_reg[1:0], debugSerialIn};
      end
   end

   // level held between agreements; the rise pulse lasts one processor cycle
   assign sclkLevel_next = sclkAgree ? sclkSync_reg[2] : sclkLevel_reg;
   wire logic sclkRise = sclkLevel_next && !sclkLevel_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclkLevel_reg <= 1'b0;
         sdiLevel_reg <= 1'b0;
      end else begin
         sclkLevel_reg <= sclkLevel_next;
         if (sdiAgree) begin
            sdiLevel_reg <= sdiSync_reg[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // serial shifter
   // ----------------------------------------------------------------
   logic [FRAME_W-1:0] rxShift_reg;
   logic [FRAME_W-1:0] txShift_reg;
   logic [4:0] bitCount_reg;
   logic [2:0] outDelay_reg;
   logic outPending_reg;
   logic serialOut_reg;
   logic rxValid_reg;
   logic [FRAME_W-1:0] rxFrame_reg;
   wire logic frameDone = sclkRise && (bitCount_reg == BIT_COUNT_LAST);
   wire logic [4:0] bitCountInc = 5'(bitCount_reg + 5'h01);
   // outFire marks the cycle in which the response bit leaves
   wire logic outFire = outPending_reg && (outDelay_reg == 3'h1);

   // first bit received ends up in the top bit of the frame
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rxShift_reg <= '0;
         bitCount_reg <= BIT_COUNT_RESET;
         rxValid_reg <= 1'b0;
         rxFrame_reg <= '0;
      end else begin
         rxValid_reg <= frameDone;
         if (sclkRise) begin
            rxShift_reg <= {rxShift_reg[FRAME_W-2:0], sdiLevel_reg};
            bitCount_reg <= frameDone ? BIT_COUNT_RESET : bitCountInc;
         end
         if (frameDone) begin
            rxFrame_reg <= {rxShift_reg[FRAME_W-2:0], sdiLevel_reg};
         end
      end
   end

   // response bit leaves a fixed delay after the shift clock is seen high
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         txShift_reg <= '0;
         outDelay_reg <= 3'h0;
         outPending_reg <= 1'b0;
         serialOut_reg <= 1'b0;
      end else begin
         if (sclkRise) begin
            outPending_reg <= 1'b1;
            outDelay_reg <= OUT_DELAY_CNT;
         end else if (outPending_reg) begin
            outDelay_reg <= 3'(outDelay_reg - 3'h1);
            if (outFire) begin
               outPending_reg <= 1'b0;
            end
         end
         // a load wins over a shift in the same cycle; that shift is lost
         if (txLoad) begin
            txShift_reg <= txFrame;
         end else if (outFire) begin
            serialOut_reg <= txShift_reg[FRAME_W-1];
            txShift_reg <= {txShift_reg[FRAME_W-2:0], 1'b0};
         end
      end
   end

   // link results straight from their registers
   assign debugSerialOut = serialOut_reg;
   assign rxFrame = rxFrame_reg;
   assign rxValid = rxValid_reg;

   // ----------------------------------------------------------------
   // trace outputs
   // ----------------------------------------------------------------
   dstp_clk_e clkState_reg;
   dstp_clk_e clkState_next;
   logic [3:0] status_reg;
   logic [3:0] nibble_reg;
   logic allOnes_reg;
   logic sampleEn_reg;
   wire logic startSeen = isStartCode(coreTrace.statusCode);
   // the disable bit alone decides whether the trace may move, in any state
   wire logic traceUpdate = !statusClockDisable;
   wire logic sampleEnNext = (clkState_next == ST_RUN);

   // a start code met with the clock disabled parks in the frozen state,
   // so the sample clock starts once the bit is cleared
   always_comb begin
      case (clkState_reg)
         ST_HALTED: begin
            if (startSeen) begin
               clkState_next = statusClockDisable ? ST_FROZEN : ST_RUN;
            end else begin
               clkState_next = ST_HALTED;
            end
         end
         ST_RUN: clkState_next = statusClockDisable ? ST_FROZEN : ST_RUN;
         ST_FROZEN: clkState_next = statusClockDisable ? ST_FROZEN : ST_RUN;
         default: clkState_next = ST_HALTED;
      endcase
   end

   // status registered each edge the disable is clear, so it tracks the core not the bus cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         clkState_reg <= ST_HALTED;
         status_reg <= STATUS_IDLE;
         nibble_reg <= NIBBLE_RESET;
         allOnes_reg <= 1'b0;
      end else begin
         clkState_reg <= clkState_next;
         if (traceUpdate) begin
            status_reg <= coreTrace.statusCode;
            nibble_reg <= coreTrace.dataNibble;
            allOnes_reg <= &coreTrace.statusCode;
         end
      end
   end

   // ----------------------------------------------------------------
   // status sample clock
   // ----------------------------------------------------------------
   // enable moves while the processor clock is high, so the gate
   // below never lets a sliver through when the enable drops
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sampleEn_reg <= 1'b0;
      end else begin
         sampleEn_reg <= sampleEnNext;
      end
   end

   assign tracePins.coreStatusCode = status_reg;
   assign tracePins.debugDataNibble = nibble_reg;
   assign tracePins.statusAllOnes = allOnes_reg;
   // high in the low half of each live cycle, so it rises mid-window
   // gated clock: clean in RTL, a netlist wants a glitch-free gating cell
   assign tracePins.statusSampleClock = sampleEn_reg && !clock;
   // triggers stay live while the trace is frozen
   assign triggerOut = triggerIn;

endmodule : dstp_port

`default_nettype wire

// ---- test/dstp_port_sva.sv ----
/* Checker of the trace pins and receive flag of dstp_port.
   Sees only the ports of dstp_port; attached by the bind at the foot. */
`default_nettype none
module dstp_port_sva
   import dstp_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire dstp_trace_s coreTrace,
   input wire logic statusClockDisable,
   input wire logic triggerIn,
   input wire logic triggerOut,
   input wire dstp_pins_s tracePins,
   input wire logic [FRAME_W-1:0] rxFrame,
   input wire logic rxValid
);
   timeunit 1ns;
   timeprecision 100ps;
   logic seen_reg;
   wire logic isStart = coreTrace.statusCode inside {STATUS_START_C, STATUS_START_D,
      STATUS_START_F};
   // sample clock may only run once a start code went in
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) seen_reg <= 1'b0;
      else if (isStart) seen_reg <= 1'b1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   AST_ALLONES: assert property (tracePins.statusAllOnes == &tracePins.coreStatusCode)
      else $error("all-ones wrong");
   AST_STATUS: assert property ($past(!statusClockDisable) |->
      tracePins.coreStatusCode == $past(coreTrace.statusCode)) else $error("status wrong");
   AST_NIBBLE: assert property ($past(!statusClockDisable) |->
      tracePins.debugDataNibble == $past(coreTrace.dataNibble)) else $error("nibble wrong");
   AST_FREEZE: assert property (statusClockDisable [*2] |=>
      $stable(tracePins.coreStatusCode) && $stable(tracePins.debugDataNibble))
      else $error("trace moved while frozen");
   AST_TRIGGER: assert property (triggerOut == triggerIn) else $error("trigger wrong");
   AST_RESUME: assert property ($fell(statusClockDisable) ##1 !statusClockDisable |=>
      tracePins.coreStatusCode == $past(coreTrace.statusCode)) else $error("no resume");
   AST_RXFRAME: assert property (!$stable(rxFrame) |-> rxValid) else $error("frame w/o flag");
   AST_START: assert property (@(posedge tracePins.statusSampleClock) disable iff (!rstn)
      seen_reg) else $error("sample clock early");
   COV_FRAME: cover property (rxValid);
   COV_RESUME: cover property ($fell(statusClockDisable));
   COV_ALLONES: cover property (tracePins.statusAllOnes);
endmodule : dstp_port_sva

bind dstp_port dstp_port_sva chk (.clock(clock), .rstn(rstn), .coreTrace(coreTrace),
   .statusClockDisable(statusClockDisable), .triggerIn(triggerIn), .triggerOut(triggerOut),
   .tracePins(tracePins), .rxFrame(rxFrame), .rxValid(rxValid));
`default_nettype wire

// ---- test/dstp_probe.sv ----
/* Development probe model: serial link master and trace sampler.
   Assumes the processor clock is given; shift clock is 80 ns. */
`default_nettype none
module dstp_probe (
   input wire logic clock,
   input wire logic statusSampleClock,
   input wire logic [3:0] coreStatusCode,
   input wire logic debugSerialOut,
   output logic debugShiftClock,
   output logic debugSerialIn,
   output logic [3:0] seenStatus,
   output int edgeCount
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      debugShiftClock = 1'b0;
      debugSerialIn = 1'b0;
   end
   always @(posedge statusSampleClock) begin
      seenStatus = coreStatusCode;
      edgeCount++;
   end
   // shift clock stands low outside frames
   task automatic frame(input logic [16:0] tx, output logic [16:0] rx);
      for (int i = 16; i >= 0; i--) begin
         debugSerialIn <= tx[i];
         @(posedge clock) debugShiftClock <= 1'b1;
         repeat (4) @(posedge clock);
         debugShiftClock <= 1'b0;
         repeat (3) @(posedge clock);
         rx[i] = debugSerialOut;
      end
      debugSerialIn <= ~debugSerialIn; // released line: not the last bit
   endtask : frame
endmodule : dstp_probe
`default_nettype wire

// ---- test/testbench.sv ----
/* Self-checking bench of dstp_port with the probe model.
   Assumes the probe model and checker are compiled first. */
`default_nettype none
module testbench import dstp_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic clkOff = 1'b0;
   logic trigIn = 1'b0;
   logic txLoad = 1'b0;
   logic shiftClk, serIn, serOut, trigOut, rxValid;
   logic [16:0] txFrame = 17'h00000;
   logic [16:0] rxFrame, rxBits;
   dstp_trace_s coreTrace = 8'h00;
   dstp_pins_s pins;
   logic [3:0] seen;
   int edges, fail_count, num_checks, cycles, e0;
   always #5 clock = ~clock;
   dstp_port dut (.clock(clock), .rstn(rstn), .debugShiftClock(shiftClk), .debugSerialIn(serIn),
      .debugSerialOut(serOut), .coreTrace(coreTrace), .statusClockDisable(clkOff),
      .triggerIn(trigIn), .triggerOut(trigOut), .tracePins(pins), .rxFrame(rxFrame),
      .rxValid(rxValid), .txFrame(txFrame), .txLoad(txLoad));
   dstp_probe probe (.clock(clock), .statusSampleClock(pins.statusSampleClock),
      .coreStatusCode(pins.coreStatusCode), .debugSerialOut(serOut), .debugShiftClock(shiftClk),
      .debugSerialIn(serIn), .seenStatus(seen), .edgeCount(edges));
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic t_start();
      logic [3:0] codes [3] = '{STATUS_START_C, STATUS_START_D, STATUS_START_F};
      for (int k = 0; k < 3; k++) begin
         @(posedge clock) rstn <= 1'b0;
         coreTrace <= 8'h00;
         e0 = edges;
         repeat (5) @(posedge clock);
         rstn <= 1'b1;
         coreTrace <= 8'h50; // non-start code must not wake the clock
         repeat (6) @(posedge clock);
         chk(edges - e0, 0);
         coreTrace <= {codes[k], 4'h0};
         repeat (4) @(posedge clock);
         chk(edges - e0 > 0, 1);
      end
   endtask : t_start
   task automatic t_trace();
      for (int v = 0; v < 16; v++) begin
         @(posedge clock) coreTrace <= {4'(v), ~4'(v)};
         @(posedge clock);
         #6;
         chk(pins.coreStatusCode, v);
         chk(pins.debugDataNibble, 4'(v) ^ 4'hF);
         chk(pins.statusAllOnes, v == 15);
         chk(seen, v);
      end
   endtask : t_trace
   task automatic t_freeze();
      @(posedge clock) coreTrace <= 8'h3A;
      @(posedge clock) clkOff <= 1'b1;
      @(posedge clock);
      e0 = edges;
      coreTrace <= 8'h5C;
      trigIn <= 1'b1;
      repeat (4) @(posedge clock);
      chk(pins.coreStatusCode, 4'h3);
      chk(edges - e0, 0);
      chk(trigOut, 1'b1);
      clkOff <= 1'b0;
      repeat (3) @(posedge clock);
      chk(pins.coreStatusCode, 4'h5);
      chk(edges - e0 > 0, 1);
   endtask : t_freeze
   task automatic t_serial();
      logic [16:0] pat [2] = '{17'h1A5C3, 17'h0E5A6};
      for (int k = 0; k < 2; k++) begin
         @(posedge clock) txFrame <= pat[k];
         txLoad <= 1'b1;
         @(posedge clock) txLoad <= 1'b0;
         probe.frame(~pat[k], rxBits);
         repeat (4) @(posedge clock);
         chk(rxFrame, ~pat[k]);
         chk(rxBits, pat[k]);
      end
   endtask : t_serial
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      t_start();
      t_trace();
      t_freeze();
      t_serial();
      final_report();
   end
endmodule : testbench
`default_nettype wire
